// *** design/teai_regs.svh ***
// register map, field positions, reset values and timing figures of the event action and irq block
`ifndef TEAI_REGS_SVH
`define TEAI_REGS_SVH

// register indexes; the APB byte address is four times the index
`define TEAI_IDX_EVENT_CTL    8'h09
`define TEAI_IDX_IRQ_ENABLE   8'h0a
`define TEAI_IDX_IRQ_FLAGS    8'h0b

// event_input_control fields
`define TEAI_EVCTL_RESET      8'h00
`define TEAI_ACTB_MSB         7
`define TEAI_ACTB_LSB         5
`define TEAI_ENB_BIT          4
`define TEAI_ACTA_MSB         3
`define TEAI_ACTA_LSB         1
`define TEAI_ENA_BIT          0

// irq_enable / irq_flags share one layout
`define TEAI_IRQ_RESET        8'h00
`define TEAI_IRQ_COMPARE_CHANNEL_TWO_IRQ_BIT     6
`define TEAI_IRQ_COMPARE_CHANNEL_ONE_IRQ_BIT     5
`define TEAI_IRQ_COMPARE_CHANNEL_ZERO_IRQ_BIT     4
`define TEAI_IRQ_WRAP_BIT     0
`define TEAI_IRQ_MASK         8'h71

// waveform modes whose wrap flag is raised at BOTTOM; all others raise it at TOP
`define TEAI_WRAP_BOTTOM_MODES 8'he0

// bus answer: cycles of access phase before pready
`define TEAI_APB_WAIT         1

`endif

// *** design/teai_pkg.sv ***
// types of the event action and irq block
package teai_pkg;

    typedef enum logic [2:0] {
        TEAI_ACTA_COUNT_RISING,
        TEAI_ACTA_COUNT_BOTH_EDGES,
        TEAI_ACTA_COUNT_GATED_LEVEL,
        TEAI_ACTA_DIRECTION_COUNT,
        TEAI_ACTA_RSV4,
        TEAI_ACTA_RSV5,
        TEAI_ACTA_RSV6,
        TEAI_ACTA_RSV7
    } teai_acta_t;

    typedef enum logic [2:0] {
        TEAI_ACTB_NONE,
        TEAI_ACTB_RSV1,
        TEAI_ACTB_RSV2,
        TEAI_ACTB_DIRECTION_COUNT,
        TEAI_ACTB_RESTART_RISING,
        TEAI_ACTB_RESTART_BOTH_EDGES,
        TEAI_ACTB_RESTART_LEVEL,
        TEAI_ACTB_RSV7
    } teai_actb_t;

    // what the counter core reports to this block
    typedef struct packed {
        logic [15:0] counterValue;
        logic [15:0] compareValue0;
        logic [15:0] compareValue1;
        logic [15:0] compareValue2;
        logic        topReached;
        logic        bottomReached;
        logic [2:0]  waveformModeSelect;
        logic        softDirection;
    } teai_core_status_t;

    // what this block asks of the counter core
    typedef struct packed {
        logic countStep;
        logic countDown;
        logic restart;
    } teai_core_ctrl_t;

endpackage

// *** design/teai_event_irq.sv ***
// event input actions, interrupt enables and sticky flags of a 16-bit timer/counter, APB slave
`timescale 1ns/100ps
`include "teai_regs.svh"

module teai_event_irq
(
    input  wire logic                        sys_clk,
    input  wire logic                        arst_n,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [7:0]                  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        eventFirst,
    input  wire logic                        eventSecond,
    input  wire logic                        prescaleTick,
    input  wire teai_pkg::teai_core_status_t coreStatus,
    output teai_pkg::teai_core_ctrl_t        coreCtrl,
    output logic                             irq
);

    logic [7:0]  eventCtl_reg;
    logic [7:0]  irqEnable_reg;
    logic [7:0]  irqFlags_reg;
    logic [7:0]  irqFlags_next;
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic        firstMeta_reg;
    logic        firstSync_reg;
    logic        firstPrev_reg;
    logic        secondMeta_reg;
    logic        secondSync_reg;
    logic        secondPrev_reg;
    logic        countStep_reg;
    logic        countDown_reg;
    logic        restart_reg;
    logic        irq_reg;

    logic        accessPhase;
    logic        writeDone;
    logic        addrHit;
    logic [7:0]  readByte;
    logic        firstEnable;
    logic        secondEnable;
    teai_pkg::teai_acta_t actionFirst;
    teai_pkg::teai_actb_t actionSecond;
    logic        firstRise;
    logic        firstBoth;
    logic        secondRise;
    logic        secondBoth;
    logic        stepFromFirst;
    logic        restartNow;
    logic        stepNow;
    logic        eventDirMode;
    logic        eventDir;
    logic [7:0]  flagSet;
    logic [7:0]  flagClear;

    // byte address of a register index
    function automatic logic [7:0] regAddr(input logic [7:0] index);
        regAddr = {index[5:0], 2'b00};
    endfunction

    // one-hot of a waveform mode against the bottom-wrap mode set
    function automatic logic wrapAtBottom(input logic [2:0] mode);
        logic [7:0] modes;
        modes = `TEAI_WRAP_BOTTOM_MODES;
        wrapAtBottom = modes[mode];
    endfunction

    // ---------------- APB slave ----------------
    // one wait state so read data can come straight from a flop
    assign accessPhase = psel && penable;
    assign writeDone   = accessPhase && pready_reg && pwrite;

    always_comb
    begin
        addrHit  = 1'b1;
        readByte = 8'h00;
        if (paddr == regAddr(`TEAI_IDX_EVENT_CTL))
        begin
            readByte = eventCtl_reg;
        end
        else if (paddr == regAddr(`TEAI_IDX_IRQ_ENABLE))
        begin
            readByte = irqEnable_reg;
        end
        else if (paddr == regAddr(`TEAI_IDX_IRQ_FLAGS))
        begin
            readByte = irqFlags_reg;
        end
        else
        begin
            addrHit = 1'b0;
        end
    end

    // ready rises in the second access cycle and drops again at once
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pready_reg <= 1'b0;
        end
        else
        begin
            pready_reg <= accessPhase && !pready_reg;
        end
    end

    // an unmapped access still completes; only the error line marks it
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pslverr_reg <= accessPhase && !pready_reg && !addrHit;
        end
    end

    // write cycles clear the read data so no stale byte lingers on the bus
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prdata_reg <= 32'h0000_0000;
        end
        else if (accessPhase && !pready_reg)
        begin
            prdata_reg <= pwrite ? 32'h0000_0000 : {24'h00_0000, readByte};
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;

    // ---------------- control registers ----------------
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            eventCtl_reg <= `TEAI_EVCTL_RESET;
        end
        else if (writeDone && paddr == regAddr(`TEAI_IDX_EVENT_CTL))
        begin
            eventCtl_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irqEnable_reg <= `TEAI_IRQ_RESET;
        end
        else if (writeDone && paddr == regAddr(`TEAI_IDX_IRQ_ENABLE))
        begin
            irqEnable_reg <= pwdata[7:0] & `TEAI_IRQ_MASK;
        end
    end

    // ---------------- event input synchronisers ----------------
    // events come from routing outside this clock's timing, so two flops first
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            firstMeta_reg <= 1'b0;
            firstSync_reg <= 1'b0;
            firstPrev_reg <= 1'b0;
        end
        else
        begin
            firstMeta_reg <= eventFirst;
            firstSync_reg <= firstMeta_reg;
            firstPrev_reg <= firstSync_reg;
        end
    end

    // same chain for input B; the previous-value flop feeds the edge detect only
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            secondMeta_reg <= 1'b0;
            secondSync_reg <= 1'b0;
            secondPrev_reg <= 1'b0;
        end
        else
        begin
            secondMeta_reg <= eventSecond;
            secondSync_reg <= secondMeta_reg;
            secondPrev_reg <= secondSync_reg;
        end
    end

    assign firstRise  = firstSync_reg && !firstPrev_reg;
    assign firstBoth  = firstSync_reg ^ firstPrev_reg;
    assign secondRise = secondSync_reg && !secondPrev_reg;
    assign secondBoth = secondSync_reg ^ secondPrev_reg;

    // ---------------- event actions ----------------
    assign firstEnable  = eventCtl_reg[`TEAI_ENA_BIT];
    assign secondEnable = eventCtl_reg[`TEAI_ENB_BIT];
    assign actionFirst  = teai_pkg::teai_acta_t'(eventCtl_reg[`TEAI_ACTA_MSB:`TEAI_ACTA_LSB]);
    assign actionSecond = teai_pkg::teai_actb_t'(eventCtl_reg[`TEAI_ACTB_MSB:`TEAI_ACTB_LSB]);

    // count source; reserved codes stop counting rather than guess a meaning
    always_comb
    begin
        stepFromFirst = prescaleTick;
        if (firstEnable)
        begin
            case (actionFirst)
                teai_pkg::TEAI_ACTA_COUNT_RISING:      stepFromFirst = firstRise;
                teai_pkg::TEAI_ACTA_COUNT_BOTH_EDGES:  stepFromFirst = firstBoth;
                teai_pkg::TEAI_ACTA_COUNT_GATED_LEVEL: stepFromFirst = prescaleTick && firstSync_reg;
                teai_pkg::TEAI_ACTA_DIRECTION_COUNT:   stepFromFirst = prescaleTick;
                default:                               stepFromFirst = 1'b0;
            endcase
        end
    end

    always_comb
    begin
        restartNow = 1'b0;
        if (secondEnable)
        begin
            case (actionSecond)
                teai_pkg::TEAI_ACTB_RESTART_RISING:     restartNow = secondRise;
                teai_pkg::TEAI_ACTB_RESTART_BOTH_EDGES: restartNow = secondBoth;
                teai_pkg::TEAI_ACTB_RESTART_LEVEL:      restartNow = secondSync_reg;
                default:                                restartNow = 1'b0;
            endcase
        end
    end

    // a restart overrides a step in the same cycle
    assign stepNow = stepFromFirst && !restartNow;

    // B direction wins when both inputs ask to steer direction
    always_comb
    begin
        eventDirMode = 1'b0;
        eventDir     = coreStatus.softDirection;
        if (secondEnable && actionSecond == teai_pkg::TEAI_ACTB_DIRECTION_COUNT)
        begin
            eventDirMode = 1'b1;
            eventDir     = secondSync_reg;
        end
        else if (firstEnable && actionFirst == teai_pkg::TEAI_ACTA_DIRECTION_COUNT)
        begin
            eventDirMode = 1'b1;
            eventDir     = firstSync_reg;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            countStep_reg <= 1'b0;
        end
        else
        begin
            countStep_reg <= stepNow;
        end
    end

    // level mode keeps this high, so the core holds its count at zero meanwhile
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            restart_reg <= 1'b0;
        end
        else
        begin
            restart_reg <= restartNow;
        end
    end

    // an event-steered direction moves only with a step, so a glitching event between steps is harmless
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            countDown_reg <= 1'b0;
        end
        else if (!eventDirMode)
        begin
            countDown_reg <= coreStatus.softDirection;
        end
        else if (stepNow)
        begin
            countDown_reg <= eventDir;
        end
    end

    assign coreCtrl.countStep = countStep_reg;
    assign coreCtrl.countDown = countDown_reg;
    assign coreCtrl.restart   = restart_reg;

    // ---------------- flags and interrupt ----------------
    always_comb
    begin
        flagSet = 8'h00;
        flagSet[`TEAI_IRQ_COMPARE_CHANNEL_ZERO_IRQ_BIT] = coreStatus.counterValue == coreStatus.compareValue0;
        flagSet[`TEAI_IRQ_COMPARE_CHANNEL_ONE_IRQ_BIT] = coreStatus.counterValue == coreStatus.compareValue1;
        flagSet[`TEAI_IRQ_COMPARE_CHANNEL_TWO_IRQ_BIT] = coreStatus.counterValue == coreStatus.compareValue2;
        flagSet[`TEAI_IRQ_WRAP_BIT] = wrapAtBottom(coreStatus.waveformModeSelect)
                                      ? coreStatus.bottomReached
                                      : coreStatus.topReached;
    end

    assign flagClear = (writeDone && paddr == regAddr(`TEAI_IDX_IRQ_FLAGS))
                       ? (pwdata[7:0] & `TEAI_IRQ_MASK) : 8'h00;

    // a hardware set in the clearing cycle wins, so no event is lost
    assign irqFlags_next = (irqFlags_reg & ~flagClear) | flagSet;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irqFlags_reg <= `TEAI_IRQ_RESET;
        end
        else
        begin
            irqFlags_reg <= irqFlags_next;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= |(irqFlags_next & irqEnable_reg);
        end
    end

    assign irq = irq_reg;

endmodule

// *** dv/teai_event_irq_props.sv ***
// assertion checker for the event action and irq block, bound to its top module
`timescale 1ns/100ps

module teai_event_irq_props
(
    input wire logic                        sys_clk,
    input wire logic                        arst_n,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [7:0]                  paddr,
    input wire logic [31:0]                 pwdata,
    input wire logic [31:0]                 prdata,
    input wire logic                        pready,
    input wire logic                        pslverr,
    input wire logic                        eventFirst,
    input wire logic                        eventSecond,
    input wire logic                        prescaleTick,
    input wire teai_pkg::teai_core_status_t coreStatus,
    input wire teai_pkg::teai_core_ctrl_t   coreCtrl,
    input wire logic                        irq
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);
    logic wrDone;
    assign wrDone = psel && penable && pready && pwrite;
    sequence s_waitReady;
        !pready ##1 pready;
    endsequence
    property p_oneWait;
        psel && $rose(penable) |-> s_waitReady;
    endproperty
    a_oneWait: assert property (p_oneWait) else $error("ready not after one wait state");
    property p_readyPulse;
        pready |=> !pready;
    endproperty
    a_readyPulse: assert property (p_readyPulse) else $error("ready longer than one cycle");
    property p_errPaired;
        pslverr |-> pready && (pwrite || prdata == 32'h0);
    endproperty
    a_errPaired: assert property (p_errPaired) else $error("bad error answer");
    property p_upperZero;
        pready && !pwrite |-> prdata[31:8] == 24'h0;
    endproperty
    a_upperZero: assert property (p_upperZero) else $error("read data upper bits set");
    // a flag clear drops irq at the write edge, an enable write one edge later
    property p_irqFall;
        $fell(irq) |-> $past(wrDone) || $past(wrDone, 2);
    endproperty
    a_irqFall: assert property (p_irqFall) else $error("irq dropped without a write");
    // edges reach the action three edges after the pin, so the cause lies a few cycles back
    property p_restartCause;
        coreCtrl.restart |-> $past(eventSecond, 2) || $past(eventSecond, 3) || $past(eventSecond, 4)
            || $past(eventSecond, 5);
    endproperty
    a_restartCause: assert property (p_restartCause) else $error("restart without event");
    property p_stepCause;
        coreCtrl.countStep |-> $past(prescaleTick) || $past(eventFirst, 2) != $past(eventFirst, 3)
            || $past(eventFirst, 3) != $past(eventFirst, 4) || $past(eventFirst, 4) != $past(eventFirst, 5);
    endproperty
    a_stepCause: assert property (p_stepCause) else $error("step without tick or edge");
    property p_dirLatch;
        $changed(coreCtrl.countDown) |-> coreCtrl.countStep || wrDone || $past(wrDone) || $past(wrDone, 2)
            || coreStatus.softDirection != $past(coreStatus.softDirection)
            || $past(coreStatus.softDirection) != $past(coreStatus.softDirection, 2);
    endproperty
    a_dirLatch: assert property (p_dirLatch) else $error("direction moved off a step");
endmodule

bind teai_event_irq teai_event_irq_props teai_event_irq_props_i (.sys_clk, .arst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .eventFirst, .eventSecond, .prescaleTick, .coreStatus,
    .coreCtrl, .irq);

// *** dv/teai_core_model.sv ***
// behavioural counter core answering the step, direction and restart requests
`timescale 1ns/100ps

module teai_core_model #(parameter logic [15:0] TOP = 16'h0010)
(
    input wire logic                      sys_clk,
    input wire logic                      arst_n,
    input wire teai_pkg::teai_core_ctrl_t coreCtrl,
    input wire logic [2:0]                modeSel,
    input wire logic                      softDir,
    output teai_pkg::teai_core_status_t   coreStatus
);
    logic [15:0] count_reg;
    logic        stepUp;
    logic        stepDown;
    assign stepUp = coreCtrl.countStep && !coreCtrl.countDown;
    assign stepDown = coreCtrl.countStep && coreCtrl.countDown;
    always_ff @(posedge sys_clk or negedge arst_n)
        if (!arst_n)
            count_reg <= 16'h0000;
        else if (coreCtrl.restart)
            count_reg <= 16'h0000;
        else if (stepUp)
            count_reg <= (count_reg == TOP) ? 16'h0000 : count_reg + 16'h0001;
        else if (stepDown)
            count_reg <= (count_reg == 16'h0000) ? TOP : count_reg - 16'h0001;
    // top and bottom are pulses on the wrapping step; compare values stay fixed
    assign coreStatus = '{counterValue: count_reg, compareValue0: 16'h0005, compareValue1: 16'h0006,
        compareValue2: 16'h0007, topReached: stepUp && count_reg == TOP,
        bottomReached: stepDown && count_reg == 16'h0000, waveformModeSelect: modeSel, softDirection: softDir};
endmodule

// *** dv/teai_event_irq_tb_top.sv ***
// self-checking bench of the event action and irq block
`timescale 1ns/100ps
`include "teai_regs.svh"

module teai_event_irq_tb_top;
    localparam logic [7:0] ADDR_CTL = `TEAI_IDX_EVENT_CTL << 2;
    localparam logic [7:0] ADDR_EN = `TEAI_IDX_IRQ_ENABLE << 2;
    localparam logic [7:0] ADDR_FLG = `TEAI_IDX_IRQ_FLAGS << 2;
    logic                        sys_clk = 1'b0;
    logic                        arst_n, psel, penable, pwrite, pready, pslverr, irq, errv;
    logic                        eventFirst, eventSecond, prescaleTick, softDir;
    logic [7:0]                  paddr;
    logic [31:0]                 pwdata, prdata, rdv;
    logic [2:0]                  modeSel;
    teai_pkg::teai_core_status_t coreStatus;
    teai_pkg::teai_core_ctrl_t   coreCtrl;
    int                          badCount = 0;
    int                          samplesChecked = 0;

    always #20 sys_clk = ~sys_clk;

    teai_event_irq teai_event_irq_i (.sys_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .eventFirst, .eventSecond, .prescaleTick, .coreStatus, .coreCtrl, .irq);
    teai_core_model #(.TOP(16'h0010)) teai_core_model_i (.sys_clk, .arst_n, .coreCtrl, .modeSel, .softDir,
        .coreStatus);

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samplesChecked, badCount);
        if (badCount == 0 && samplesChecked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp)
        begin
            badCount++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one transfer; the request stays put until pready is sampled high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++)
        begin
            @(posedge sys_clk);
            if (pready === 1'b1)
                break;
        end
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 16)
        begin
            badCount++;
            finish_test();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        cmp(rdv, e);
    endtask

    task automatic look(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    // r: control byte, then event A, event B, tick, expected direction, steps[3:2], restarts[1:0]
    task automatic row(input logic [15:0] r);
        int s;
        int q;
        s = 0;
        q = 0;
        wr(ADDR_CTL, r[15:8]);
        eventFirst <= r[7];
        eventSecond <= r[6];
        for (int i = 0; i < 12; i++)
        begin
            prescaleTick <= (i == 4) && r[5];
            @(negedge sys_clk);
            s += (coreCtrl.countStep === 1'b1);
            q += (coreCtrl.restart === 1'b1);
            @(posedge sys_clk);
        end
        cmp(s, r[3:2]);
        cmp(q, r[1:0]);
        cmp(coreCtrl.countDown, r[4]);
    endtask

    initial
    begin
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        eventFirst = 1'b0;
        eventSecond = 1'b0;
        prescaleTick = 1'b0;
        modeSel = 3'h0;
        softDir = 1'b0;
        repeat (10) @(posedge sys_clk);
        arst_n <= 1'b1;
        rd(ADDR_CTL, 32'h0);
        rd(ADDR_EN, 32'h0);
        rd(ADDR_FLG, 32'h0);
        apb(1'b0, 8'h30, 32'h0);
        cmp({rdv[30:0], errv}, 32'h1);
        wr(ADDR_CTL, 8'ha5);
        rd(ADDR_CTL, 32'ha5);
        wr(ADDR_EN, 8'hff);
        rd(ADDR_EN, 32'h71);
        wr(ADDR_EN, 8'h00);
        row(16'h0024);
        row(16'h0080);
        row(16'h0100);
        row(16'h0184);
        row(16'h0304);
        row(16'h0520);
        row(16'h05a4);
        row(16'h07b4);
        row(16'h0710);
        row(16'h0724);
        row(16'h09a0);
        row(16'h7774);
        row(16'h8000);
        row(16'h8040);
        row(16'h9000);
        row(16'h9041);
        row(16'hb001);
        row(16'hb041);
        row(16'h1000);
        row(16'h3040);
        row(16'hf040);
        wr(ADDR_CTL, 8'hd0);
        look(8);
        cmp(coreCtrl.restart, 1'b1);
        @(posedge sys_clk);
        eventSecond <= 1'b0;
        look(8);
        cmp(coreCtrl.restart, 1'b0);
        wr(ADDR_FLG, 8'h71);
        rd(ADDR_FLG, 32'h00);
        repeat (7) row(16'h0024);
        rd(ADDR_FLG, 32'h70);
        wr(ADDR_FLG, 8'h00);
        rd(ADDR_FLG, 32'h70);
        wr(ADDR_EN, 8'h10);
        look(1);
        cmp(irq, 1'b1);
        wr(ADDR_FLG, 8'h10);
        look(0);
        cmp(irq, 1'b0);
        wr(ADDR_FLG, 8'h60);
        rd(ADDR_FLG, 32'h40);
        repeat (10) row(16'h0024);
        rd(ADDR_FLG, 32'h41);
        wr(ADDR_EN, 8'h01);
        look(1);
        cmp(irq, 1'b1);
        wr(ADDR_FLG, 8'h41);
        rd(ADDR_FLG, 32'h00);
        modeSel <= 3'h5;
        softDir <= 1'b1;
        row(16'h0034);
        rd(ADDR_FLG, 32'h01);
        finish_test();
    end
endmodule
